// File: lpg_gen_mon.sv
// lpg_gen_mon: traffic generator and checker for the segmented
// local bus of a chip-to-chip packet core, with a small register port.
// assumes the core's bus signals are synchronous to clk_i.
//
// Function
// - generator idles until reset done
// - lock setup drives fixed control values
// - wait for core or user alignment
// - enable state raises transmit enable
// - start sending after init and ready
// - first transmit state opens each packet
// - preset packet count reached leads done
// - ready low sends generator to hold
// - hold returns to the state left
// - second state finishes packet, back first
// - done sets flag, restart clears busy
// - monitor idles until reset done
// - lock state raises locked and busy
// - after alignment enable receive, then receive
// - per-segment data, channel and empty checks
// - any mismatch sets sticky error
// - preset count received leads done
// - done output and failed from error
// - restart waits for delayed restart request
// - flow parameter one packet, zero burst
// - never transfer while ready is low
// - segment fields valid only with enable
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module lpg_gen_mon #(
  parameter logic FLOW_MODE = 1'b1            // 1 packet, 0 burst
) (
  input  wire logic                clk_i,             // user bus clock
  input  wire logic                reset_n_i,         // sync reset
  input  wire logic                reset_done_i,      // core reset done
  input  wire logic                rx_aligned_i,      // core rx aligned
  input  wire logic                tx_rdy_i,          // core tx ready
  input  wire lpg_pkg::lpg_beat_type rx_beat_i,       // core rx bus
  input  wire logic [3:0]          addr_i,            // register index
  input  wire logic [31:0]         wdata_i,           // write data
  input  wire logic                wr_i,              // write strobe
  input  wire logic                rd_i,              // read strobe
  output logic [31:0]              rdata_o,           // read data
  output lpg_pkg::lpg_beat_type    tx_beat_o,         // core tx bus
  output logic                     ctl_tx_enable_o,   // tx enable
  output logic [7:0]               ctl_tx_mubits_o,   // multi-use bits
  output logic [11:0]              ctl_tx_lanestat_o, // lane status
  output logic                     ctl_tx_intfstat_o, // interface stat
  output logic                     rx_enable_o,       // rx enable
  output logic                     monitor_locked_status_o, // locked
  output logic                     gen_busy_o,        // generator busy
  output logic                     mon_done_o,        // monitor done
  output logic                     mon_failed_o       // monitor failed
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    lpg_pkg::lpg_gen_state_type gst;      // generator state
    logic                       hold_tx1; // hold came from second state
    logic                       init_done;// generator init complete
    logic                       busy;     // generator busy
    logic                       tx_done;  // all packets sent
    logic                       tx_en;    // core transmit enable
    logic [7:0]                 mubits;   // multi-use bits
    logic [11:0]                lanestat; // lane status bits
    logic                       intfstat; // interface status
    logic [15:0]                gpkt;     // packets sent
    logic [7:0]                 gbeat;    // beat within packet
    lpg_pkg::lpg_beat_type      tx;       // presented beat
    lpg_pkg::lpg_mon_state_type mst;      // monitor state
    logic                       locked;   // monitor locked status
    logic                       rx_busy;  // monitor busy
    logic                       rx_en;    // receive enable
    logic                       rx_done;  // all packets received
    logic                       done;     // done output
    logic                       failed;   // failed output
    logic [3:0]                 err_data; // data mismatch per segment
    logic [3:0]                 err_chan; // channel mismatch per segment
    logic                       err_mty;  // empty count mismatch
    logic                       sticky;   // sticky receive error
    logic [15:0]                mpkt;     // packets received
    logic [7:0]                 mbeat;    // expected beat
    logic [2:0]                 rst_dly;  // restart request delay line
    logic                       simplex;  // transmit-only config
    logic                       u_align;  // user alignment
    logic [31:0]                rdata;    // read data
  } lpg_state_type;

  lpg_state_type s;       // registered state
  lpg_state_type next_s;  // next state

  // ----------------------------------------------------------------
  // next state logic
  // ----------------------------------------------------------------
  // builds one beat of a packet from the shared pattern
  function automatic lpg_pkg::lpg_beat_type mk_beat(
      input logic [15:0] pkt, input logic [7:0] beat);
    lpg_pkg::lpg_beat_type b;
    for (int i = 0; i < lpg_pkg::NSEG; i++) begin
      b[i].ena  = 1'b1;
      b[i].sop  = (beat == 8'h00) && (i == 0);
      b[i].eop  = (beat == lpg_pkg::LAST_BEAT) && (i == lpg_pkg::NSEG-1);
      b[i].err  = 1'b0;
      b[i].mty  = b[i].eop ? lpg_pkg::lpg_mty(pkt) : 4'h0;
      b[i].chan = lpg_pkg::lpg_chan(pkt, FLOW_MODE);
      b[i].data = lpg_pkg::lpg_data(pkt, beat, 8'(i));
    end
    return b;
  endfunction

  // one process computes every next value
  always_comb begin
    logic [3:0] mty_exp;
    mty_exp = 4'h0;
    next_s = s;
    next_s.tx = '0;                     // no transfer unless sent
    next_s.err_data = 4'h0;
    next_s.err_chan = 4'h0;
    next_s.err_mty = 1'b0;
    next_s.rdata = 32'h0000_0000;
    // register port: control write, reads answer next cycle
    next_s.rst_dly = {s.rst_dly[1:0],
                      wr_i && (addr_i == lpg_pkg::REG_CTRL) &&
                      wdata_i[lpg_pkg::CTL_RESTART]};
    if (wr_i && (addr_i == lpg_pkg::REG_CTRL)) begin
      next_s.simplex = wdata_i[lpg_pkg::CTL_SIMPLEX];
      next_s.u_align = wdata_i[lpg_pkg::CTL_ALIGN];
    end
    if (rd_i) begin
      unique case (addr_i)
        lpg_pkg::REG_CTRL: next_s.rdata = {30'h0, s.u_align, s.simplex};
        lpg_pkg::REG_STAT: next_s.rdata = {8'h0, s.mpkt[7:0],
                            s.gpkt[7:0], s.tx_done, s.rx_done,
                            s.rx_busy, s.locked, s.busy, s.sticky,
                            s.done, s.failed};
        default:           next_s.rdata = 32'h0000_0000; // unmapped
      endcase
    end
    // generator controller
    unique case (s.gst)
      lpg_pkg::G_IDLE: begin
        if (reset_done_i) begin
          next_s.gst = lpg_pkg::G_LOCK;
          next_s.busy = 1'b1;
        end
      end
      lpg_pkg::G_LOCK: begin
        next_s.tx_en = 1'b0;
        next_s.mubits = lpg_pkg::MUBITS_OFF;
        next_s.lanestat = lpg_pkg::LANESTAT_ON;
        next_s.intfstat = 1'b1;
        next_s.init_done = 1'b0;
        next_s.tx_done = 1'b0;
        next_s.gst = lpg_pkg::G_WAIT;
      end
      lpg_pkg::G_WAIT: begin
        if (s.simplex ? s.u_align : rx_aligned_i) begin
          next_s.gst = lpg_pkg::G_EN;
        end
      end
      lpg_pkg::G_EN: begin
        next_s.tx_en = 1'b1;
        next_s.gst = lpg_pkg::G_INIT;
      end
      lpg_pkg::G_INIT: begin
        next_s.gpkt = 16'h0;
        next_s.gbeat = 8'h0;
        next_s.init_done = 1'b1;
        if (s.init_done && tx_rdy_i) begin
          next_s.gst = lpg_pkg::G_TX0;
        end
      end
      lpg_pkg::G_TX0: begin
        if (s.gpkt == lpg_pkg::GEN_PKTS) begin
          next_s.gst = lpg_pkg::G_DONE;
        end else if (!tx_rdy_i) begin
          next_s.gst = lpg_pkg::G_HOLD;
          next_s.hold_tx1 = 1'b0;
        end else begin
          next_s.tx = mk_beat(s.gpkt, 8'h00);
          next_s.gbeat = 8'h01;
          next_s.gst = lpg_pkg::G_TX1;
        end
      end
      lpg_pkg::G_TX1: begin
        if (!tx_rdy_i) begin
          next_s.gst = lpg_pkg::G_HOLD;
          next_s.hold_tx1 = 1'b1;
        end else begin
          next_s.tx = mk_beat(s.gpkt, s.gbeat);
          if (s.gbeat == lpg_pkg::LAST_BEAT) begin
            next_s.gbeat = 8'h00;
            next_s.gpkt = s.gpkt + 16'h1;
            next_s.gst = lpg_pkg::G_TX0;
          end else begin
            next_s.gbeat = s.gbeat + 8'h1;
          end
        end
      end
      lpg_pkg::G_HOLD: begin
        if (tx_rdy_i) begin
          next_s.gst = s.hold_tx1 ? lpg_pkg::G_TX1 : lpg_pkg::G_TX0;
        end
      end
      lpg_pkg::G_DONE: begin
        next_s.tx_done = 1'b1;
        next_s.gst = lpg_pkg::G_RST;
      end
      lpg_pkg::G_RST: begin
        next_s.busy = 1'b0;
        next_s.gst = lpg_pkg::G_IDLE;
      end
      default: next_s.gst = lpg_pkg::G_IDLE;    // illegal code recovery
    endcase
    // monitor controller
    unique case (s.mst)
      lpg_pkg::M_IDLE: begin
        if (reset_done_i) next_s.mst = lpg_pkg::M_LOCK;
      end
      lpg_pkg::M_LOCK: begin
        next_s.locked = 1'b1;
        next_s.rx_busy = 1'b1;
        next_s.mst = lpg_pkg::M_WAIT;
      end
      lpg_pkg::M_WAIT: begin
        if (rx_aligned_i) next_s.mst = lpg_pkg::M_EN;
      end
      lpg_pkg::M_EN: begin
        next_s.rx_en = 1'b1;
        next_s.mst = lpg_pkg::M_INIT;
      end
      lpg_pkg::M_INIT: begin
        next_s.mpkt = 16'h0;
        next_s.mbeat = 8'h0;
        next_s.rx_done = 1'b0;
        next_s.done = 1'b0;
        next_s.mst = lpg_pkg::M_RECV;
      end
      lpg_pkg::M_RECV: begin
        // compare each enabled segment with the expected pattern
        for (int i = 0; i < lpg_pkg::NSEG; i++) begin
          mty_exp = rx_beat_i[i].eop ? lpg_pkg::lpg_mty(s.mpkt) : 4'h0;
          if (rx_beat_i[i].ena) begin
            next_s.err_data[i] = rx_beat_i[i].data !=
                lpg_pkg::lpg_data(s.mpkt, s.mbeat, 8'(i));
            next_s.err_chan[i] = rx_beat_i[i].chan !=
                lpg_pkg::lpg_chan(s.mpkt, FLOW_MODE);
            if (rx_beat_i[i].mty != mty_exp) next_s.err_mty = 1'b1;
          end
        end
        if (rx_beat_i[0].ena) next_s.mbeat = s.mbeat + 8'h1;
        if (rx_beat_i[lpg_pkg::NSEG-1].ena &&
            rx_beat_i[lpg_pkg::NSEG-1].eop) begin
          next_s.mpkt = s.mpkt + 16'h1;
          next_s.mbeat = 8'h0;
        end
        if (s.mpkt == lpg_pkg::MON_PKTS) next_s.mst = lpg_pkg::M_DONE;
      end
      lpg_pkg::M_DONE: begin
        next_s.rx_done = 1'b1;
        next_s.mst = lpg_pkg::M_MODE;
      end
      lpg_pkg::M_MODE: begin
        next_s.done = 1'b1;
        next_s.failed = s.sticky;
        next_s.mst = lpg_pkg::M_RST;
      end
      lpg_pkg::M_RST: begin
        next_s.rx_en = 1'b0;
        next_s.mpkt = 16'h0;
        next_s.mbeat = 8'h0;
        next_s.rx_busy = 1'b0;
        if (s.rst_dly[lpg_pkg::RESTART_DLY]) next_s.mst = lpg_pkg::M_IDLE;
      end
      default: next_s.mst = lpg_pkg::M_IDLE;    // illegal code recovery
    endcase
    // sticky error, cleared only by reset
    if (s.sticky || (|s.err_data) || (|s.err_chan) || s.err_mty) begin
      next_s.sticky = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // synchronous reset returns both controllers to idle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign rdata_o                 = s.rdata;
  assign tx_beat_o               = s.tx;
  assign ctl_tx_enable_o         = s.tx_en;
  assign ctl_tx_mubits_o         = s.mubits;
  assign ctl_tx_lanestat_o       = s.lanestat;
  assign ctl_tx_intfstat_o       = s.intfstat;
  assign rx_enable_o             = s.rx_en;
  assign monitor_locked_status_o = s.locked;
  assign gen_busy_o              = s.busy;
  assign mon_done_o              = s.done;
  assign mon_failed_o            = s.failed;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_gen_idle_hold: assert property (
    s.gst == lpg_pkg::G_IDLE && !reset_done_i |=> s.gst == lpg_pkg::G_IDLE)
    else $error("generator left idle without reset done");

  // enable may wait on alignment for any time, so only the setup is held
  a_lock_setup_values: assert property (
    s.gst == lpg_pkg::G_LOCK |=> !ctl_tx_enable_o &&
      ctl_tx_lanestat_o == 12'hfff && ctl_tx_intfstat_o &&
      ctl_tx_mubits_o == 8'h00 && !s.init_done &&
      s.gst == lpg_pkg::G_WAIT)
    else $error("lock setup values or next state wrong");

  a_align_gate: assert property (
    s.gst == lpg_pkg::G_WAIT && !(s.simplex ? s.u_align : rx_aligned_i)
      |=> s.gst == lpg_pkg::G_WAIT)
    else $error("generator left wait without alignment");

  a_no_send_unready: assert property (
    (s.gst inside {lpg_pkg::G_TX0, lpg_pkg::G_TX1}) && !tx_rdy_i
      |=> !tx_beat_o[0].ena && s.gst inside {lpg_pkg::G_HOLD,
      lpg_pkg::G_DONE})
    else $error("transfer presented while ready low");

  a_hold_return: assert property (
    s.gst == lpg_pkg::G_HOLD && tx_rdy_i
      |=> s.gst == ($past(s.hold_tx1) ? lpg_pkg::G_TX1 : lpg_pkg::G_TX0))
    else $error("hold returned to wrong transmit state");

  a_sop_with_ena: assert property (
    tx_beat_o[0].sop |-> tx_beat_o[0].ena && !tx_beat_o[3].eop)
    else $error("start marker without enable");

  a_sticky_error: assert property (
    (|s.err_data) || (|s.err_chan) || s.err_mty |=> s.sticky [*3])
    else $error("mismatch did not set sticky error");

  a_restart_clears_busy: assert property (
    s.gst == lpg_pkg::G_RST |=> !gen_busy_o && s.gst == lpg_pkg::G_IDLE)
    else $error("restart state did not clear generator busy");

  a_done_sets_flag: assert property (
    s.mst == lpg_pkg::M_DONE |=> s.rx_done && s.mst == lpg_pkg::M_MODE)
    else $error("monitor done state did not set receive done");

  a_done_failed: assert property (
    s.mst == lpg_pkg::M_MODE |=> mon_done_o && mon_failed_o == $past(s.sticky))
    else $error("done or failed output wrong");

  a_restart_wait: assert property (
    s.mst == lpg_pkg::M_RST && !s.rst_dly[2] |=> s.mst == lpg_pkg::M_RST)
    else $error("monitor left restart without request");

  c_gen_done: cover property (s.gst == lpg_pkg::G_DONE);
  c_gen_hold: cover property (s.gst == lpg_pkg::G_HOLD ##1 tx_rdy_i);
  c_mon_failed: cover property (mon_done_o && mon_failed_o);
  c_mon_restart: cover property (s.mst == lpg_pkg::M_RST ##1
                                 s.mst == lpg_pkg::M_IDLE);

endmodule

`default_nettype wire

// File: lpg_pkg.sv
// lpg_pkg: constants, types and pattern functions for the packet
// generator and monitor on the segmented local bus.
// assumes one user bus clock and a synchronous active-low reset.
package lpg_pkg;

  // ----------------------------------------------------------------
  // bus shape and traffic figures
  // ----------------------------------------------------------------
  localparam int unsigned  NSEG       = 4;        // segments per beat
  localparam int unsigned  DATA_W     = 128;      // bits per segment
  localparam int unsigned  CHAN_W     = 11;       // channel width
  localparam logic [15:0]  GEN_PKTS   = 16'h000a; // packets to send
  localparam logic [15:0]  MON_PKTS   = 16'h000a; // packets to expect
  localparam logic [7:0]   LAST_BEAT  = 8'h02;    // three beats a packet
  localparam logic [11:0]  LANESTAT_ON = 12'hfff; // all lanes healthy
  localparam logic [7:0]   MUBITS_OFF = 8'h00;    // multi-use bits idle
  localparam logic [1:0]   RESTART_DLY = 2'h2;    // restart delay tap

  // ----------------------------------------------------------------
  // register port map
  // ----------------------------------------------------------------
  localparam logic [3:0]   REG_CTRL   = 4'h0;     // control, rw
  localparam logic [3:0]   REG_STAT   = 4'h1;     // status, ro
  localparam int unsigned  CTL_SIMPLEX = 0;       // tx-only config
  localparam int unsigned  CTL_ALIGN  = 1;        // user alignment
  localparam int unsigned  CTL_RESTART = 2;       // restart, write one

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              ena;   // segment transfer enable
    logic              sop;   // start of packet
    logic              eop;   // end of packet
    logic              err;   // error marker
    logic [3:0]        mty;   // empty bytes on eop
    logic [CHAN_W-1:0] chan;  // channel number
    logic [DATA_W-1:0] data;  // segment data
  } lpg_seg_type;

  typedef lpg_seg_type [NSEG-1:0] lpg_beat_type;

  typedef enum logic [3:0] {G_IDLE, G_LOCK, G_WAIT, G_EN, G_INIT,
                            G_TX0, G_TX1, G_HOLD, G_DONE, G_RST
                           } lpg_gen_state_type;

  typedef enum logic [3:0] {M_IDLE, M_LOCK, M_WAIT, M_EN, M_INIT,
                            M_RECV, M_DONE, M_MODE, M_RST
                           } lpg_mon_state_type;

  // ----------------------------------------------------------------
  // shared traffic pattern
  // ----------------------------------------------------------------
  // data word of one segment: packet, beat and segment numbers
  function automatic logic [DATA_W-1:0] lpg_data(
      input logic [15:0] pkt, input logic [7:0] beat,
      input logic [7:0] seg);
    lpg_data = {4{pkt, beat, seg}};
  endfunction

  // channel of a packet: per packet in burst flow, fixed otherwise
  function automatic logic [CHAN_W-1:0] lpg_chan(
      input logic [15:0] pkt, input logic flow);
    lpg_chan = flow ? '0 : pkt[CHAN_W-1:0];
  endfunction

  // empty count carried on the closing segment
  function automatic logic [3:0] lpg_mty(input logic [15:0] pkt);
    lpg_mty = pkt[3:0];
  endfunction

endpackage

// File: lpg_core_model.sv
// lpg_core_model: behavioural stand-in for the packet core's user bus.
// assumes it shares clk_i with the block and loops tx beats back to rx.
`timescale 1ns/100ps
`default_nettype none

module lpg_core_model (
  input  wire logic                  clk_i,     // user bus clock
  input  wire logic                  stall_i,   // back-pressure request
  input  wire logic                  corrupt_i, // flip one data bit
  input  wire lpg_pkg::lpg_beat_type tx_beat_i, // beats from the block
  output logic                       tx_rdy_o,  // ready to the block
  output lpg_pkg::lpg_beat_type      rx_beat_o  // beats to the block
);
  // ------------------------------------------------------------
  // ready and loopback
  // ------------------------------------------------------------
  assign tx_rdy_o = ~stall_i;

  initial rx_beat_o = '0;

  // one cycle of latency; idle segments scramble so nothing stale matches
  always @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      rx_beat_o[i] <= tx_beat_i[i];
      if (!tx_beat_i[i].ena) begin
        rx_beat_o[i].data <= ~rx_beat_o[i].data;
      end
    end
    // damaged payload on demand
    if (corrupt_i) begin
      rx_beat_o[0].data[0] <= ~tx_beat_i[0].data[0];
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
// testbench: drives lpg_gen_mon through its register port and a
// looped-back core model; checks beats, controls and verdicts.
// assumes one 10 MHz clock shared by the block and the core model.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic                  clk_i = 1'b0;        // user bus clock
  logic                  reset_n_i = 1'b0;    // sync reset
  logic                  reset_done_i = 1'b0; // core reset done
  logic                  rx_aligned_i = 1'b0; // core rx aligned
  logic                  tx_rdy_i;            // from core model
  lpg_pkg::lpg_beat_type rx_beat_i;           // from core model
  lpg_pkg::lpg_beat_type tx_beat_o;           // to core model
  logic [3:0]            addr_i = 4'h0;       // register index
  logic [31:0]           wdata_i = 32'h0;     // write data
  logic                  wr_i = 1'b0;         // write strobe
  logic                  rd_i = 1'b0;         // read strobe
  logic [31:0]           rdata_o;             // read data
  logic [31:0]           d;                   // last read value
  logic [11:0]           lst;                 // lane status
  logic [7:0]            mub;                 // multi-use bits
  logic                  ist, en, rxen, lock, busy, done, fail;
  logic                  stall = 1'b0;        // model back-pressure
  logic                  corrupt = 1'b0;      // model damage
  logic                  rnd = 1'b0;          // random stalls on
  logic                  watch = 1'b0;        // beat checking on
  logic                  rdy_q = 1'b0;        // ready at last edge
  logic                  busy_q = 1'b0;       // busy at last edge
  int                    busy_falls = 0;      // generator busy drops
  integer                seed = 97;           // fixed random seed
  int                    mismatches = 0;
  int                    checks = 0;
  int                    gp, gb, n;           // packet, beat, loop

  always #50 clk_i = ~clk_i;

  lpg_gen_mon #(.FLOW_MODE(1'b1)) dut (.clk_i, .reset_n_i, .reset_done_i,
    .rx_aligned_i, .tx_rdy_i, .rx_beat_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .tx_beat_o, .ctl_tx_enable_o(en),
    .ctl_tx_mubits_o(mub), .ctl_tx_lanestat_o(lst),
    .ctl_tx_intfstat_o(ist), .rx_enable_o(rxen),
    .monitor_locked_status_o(lock), .gen_busy_o(busy),
    .mon_done_o(done), .mon_failed_o(fail));

  lpg_core_model core (.clk_i, .stall_i(stall), .corrupt_i(corrupt),
    .tx_beat_i(tx_beat_o), .tx_rdy_o(tx_rdy_i), .rx_beat_o(rx_beat_i));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [146:0] e, g);
    checks++;
    if (e !== g) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask

  // expected segment of packet p, beat b
  function automatic logic [146:0] exp_seg(int p, int b, int s);
    lpg_pkg::lpg_seg_type x;
    x = '0;
    x.ena = 1'b1;
    x.sop = (b == 0 && s == 0);
    x.eop = (b == 2 && s == 3);
    x.mty = x.eop ? p[3:0] : 4'h0;
    x.data = {4{p[15:0], b[7:0], s[7:0]}};
    return x;
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // random stalls and transmit bus watcher
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    rdy_q <= tx_rdy_i;
    busy_q <= busy;
    if (busy_q === 1'b1 && busy === 1'b0) busy_falls++;
    stall <= rnd && (($random(seed) & 3) == 0);
  end

  always @(negedge clk_i) begin
    if (watch && tx_beat_o[0].ena === 1'b1 && gp < 10) begin
      chk("ready before beat", 1, rdy_q);
      for (int s = 0; s < 4; s++) begin
        chk("segment", exp_seg(gp, gb, s), tx_beat_o[s]);
      end
      gb = (gb == 2) ? 0 : gb + 1;
      if (gb == 0) gp++;
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (11) @(posedge clk_i);
    @(negedge clk_i);
    chk("reset", 0, {lst, en, rxen, lock, busy, done, fail, rdata_o});
    chk("reset ctl", 0, {ist, mub});
    chk("reset beat", 0, tx_beat_o[0]);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    wr(4'h0, 32'h3);
    rd(4'h0);
    chk("control", 32'h3, d);
    wr(4'h1, 32'hffff_ffff);
    rd(4'h7);
    chk("unmapped", 0, d);
    wr(4'h0, 32'h0);
    rd(4'h1);
    chk("idle", 0, {d, lst, lock});
    // normal run with random back-pressure
    @(posedge clk_i);
    reset_done_i <= 1'b1;
    for (n = 0; n < 5 && lst !== 12'hfff; n++) @(negedge clk_i);
    chk("lock setup", {12'hfff, 10'h200}, {lst, ist, mub, en});
    repeat (20) @(negedge clk_i);
    chk("unaligned", 3'b100, {lock, en, rxen});
    gp = 0;
    gb = 0;
    watch = 1'b1;
    @(posedge clk_i);
    rx_aligned_i <= 1'b1;
    rnd <= 1'b1;
    for (n = 0; n < 8 && {en, rxen} !== 2'b11; n++) @(negedge clk_i);
    chk("enables", 2'b11, {en, rxen});
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk_i);
    chk("first run", {2'b10, 4'ha}, {done, fail, gp[3:0]});
    chk("busy falls", 1, busy_falls);
    rd(4'h1);
    chk("status", 3'b010, d[2:0]);
    chk("rx done", 3'b101, d[6:4]);
    // transmit-only run with damaged payload
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    reset_done_i <= 1'b0;
    corrupt <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wr(4'h0, 32'h1);
    @(posedge clk_i);
    reset_done_i <= 1'b1;
    repeat (20) @(negedge clk_i);
    chk("no user align", 2'b01, {en, rxen});
    wr(4'h0, 32'h3);
    for (n = 0; n < 8 && en !== 1'b1; n++) @(negedge clk_i);
    chk("user align", 1, en);
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk_i);
    chk("damaged run", 2'b11, {done, fail});
    repeat (30) @(negedge clk_i);
    chk("waits restart", 1, done);
    wr(4'h0, 32'h7);
    repeat (15) @(negedge clk_i);
    chk("restarted", 0, done);
    rd(4'h1);
    chk("sticky", 1, d[2]);
    wrap_up();
  end

  // hang guard, well beyond both runs
  initial begin
    #(100 * 20000);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
